// ---- core/event_buffer_command_control.sv ----
// Purpose: command decode, event buffer pointers, trigger count, config registers
// Assumes: instruction strobe and write line active low, synchronous to ref_clk
// Notes: data path arithmetic lives elsewhere; threshold, window, datapath and buffer config leave as ports, coefficients and pedestals stay internal
`timescale 1ns/1ns
module event_buffer_command_control
  import evbuf_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [39:0] bus_in,
  output logic [39:0] bus_out,
  output logic [39:0] bus_oe,
  input wire logic instr_strobe_n,
  input wire logic write_n,
  output logic ack_n,
  output logic transfer_active,
  output logic data_strobe_n,
  input wire logic level_one_trigger,
  input wire logic acquisition_busy,
  input wire logic [7:0] hardwired_chip_id,
  input wire logic [9:0] pedestal_variable,
  input wire logic [7:0] event_length,
  input wire logic [39:0] dump_data,
  output logic trigger_pulse,
  output logic [2:0] write_pointer,
  output logic [2:0] read_pointer,
  output logic [19:0] suppression_offset_threshold,
  output logic [19:0] baseline_window_thresholds,
  output logic [19:0] acquisition_window_config,
  output logic [19:0] datapath_config,
  output logic [3:0] pretrigger_samples,
  output logic power_save,
  output logic filter_force,
  output logic eight_buffers
);
  logic [15:0] level_one_trigger_count;
  logic [15:0] coeff [num_channels][6];
  logic [9:0] fixed_pedestal [num_channels];
  logic [9:0] pedestal_memory_word;
  logic [9:0] pedestal_memory_pointer;
  logic [6:0] buffers_pretrigger_config;
  logic [7:0] errors;
  logic [3:0] used;
  bus_state_t state;
  logic dump_go;
  logic [7:0] dump_count;
  logic [1:0] gap_count;
  logic [3:0] chan;
  logic [4:0] code;
  logic broadcast_flag;
  logic is_read;
  logic take;
  logic reg_wr;
  logic valid_code;
  logic bad_mode;
  logic cmd_wp;
  logic cmd_rp;
  logic cmd_trig;
  logic trig_any;
  logic full;
  logic empty;
  logic [3:0] capacity;
  logic [2:0] step;
  logic [19:0] next_read_value;
  logic [3:0] remaining;
  logic dump_req;
  logic dump_empty;
  logic clr_err;
  logic clr_trig;
  logic [7:0] err_set;

  assign chan = bus_in[28:25];
  assign code = bus_in[24:20];
  assign broadcast_flag = bus_in[broadcast_flag_bit];
  assign is_read = write_n;
  assign take = (state == st_idle) && !instr_strobe_n;
  assign capacity = eight_buffers ? 4'h8 : 4'h4;
  assign step = eight_buffers ? 3'h1 : 3'h2;
  assign full = (used == capacity);
  assign empty = (used == 4'h0);
  assign remaining = capacity - used;

  always_comb begin
    valid_code = 1'b1;
    bad_mode = 1'b0;
    unique case (code)
      code_pole_1,
      code_pole_2,
      code_pole_3,
      code_zero_1,
      code_zero_2,
      code_zero_3,
      code_pedestal,
      code_ped_word,
      code_zs_thr,
      code_bc_thr,
      code_acq_cfg,
      code_dp_cfg,
      code_buf_cfg,
      code_ped_ptr: bad_mode = is_read && broadcast_flag;
      // read-only registers refuse writes and broadcast reads
      code_status,
      code_id_len,
      code_trig_cnt: bad_mode = !is_read || broadcast_flag;
      code_dump: bad_mode = broadcast_flag || is_read;
      // commands carry no answer, so a read of one is refused
      code_wp_adv,
      code_rp_adv,
      code_soft_trig,
      code_clr_trig,
      code_clr_err: bad_mode = is_read;
      default: valid_code = 1'b0;
    endcase
  end

  // argument-free commands ignore bits 19:0, which may float
  assign reg_wr = take && valid_code && !bad_mode && !is_read;
  assign cmd_wp = reg_wr && code == code_wp_adv && !full;
  assign cmd_rp = reg_wr && code == code_rp_adv && !empty;
  assign cmd_trig = reg_wr && code == code_soft_trig;
  assign trig_any = level_one_trigger || cmd_trig;
  assign clr_err = reg_wr && code == code_clr_err;
  assign clr_trig = reg_wr && code == code_clr_trig;
  assign dump_req = valid_code && !bad_mode && code == code_dump;
  assign dump_empty = take && dump_req && empty;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      trigger_pulse <= 1'b0;
    end else begin
      trigger_pulse <= trig_any && !full;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      level_one_trigger_count <= trig_count_reset;
    end else if (clr_trig) begin
      // a trigger in the clear cycle is not lost
      level_one_trigger_count <= trig_count_reset + 16'(trig_any);
    end else if (trig_any) begin
      level_one_trigger_count <= level_one_trigger_count + 16'h0001;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      write_pointer <= 3'h0;
    end else if (cmd_wp) begin
      write_pointer <= write_pointer + step;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      read_pointer <= 3'h0;
    end else if (cmd_rp) begin
      read_pointer <= read_pointer + step;
    end
  end

  // occupancy; simultaneous push and pop keeps the count
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      used <= 4'h0;
    end else if (cmd_wp && !cmd_rp) begin
      used <= used + 4'h1;
    end else if (cmd_rp && !cmd_wp) begin
      used <= used - 4'h1;
    end
  end

  genvar gc;
  generate
    for (gc = 0; gc < num_channels; gc++) begin : g_chan
      always_ff @(posedge ref_clk) begin
        if (reset) begin
          for (int k = 0; k < 6; k++) begin
            coeff[gc][k] <= 16'h0000;
          end
          fixed_pedestal[gc] <= 10'h000;
        end else if (reg_wr && (broadcast_flag || chan == gc)) begin
          if (code <= code_zero_3) begin
            coeff[gc][code[2:0]] <= bus_in[15:0];
          end
          if (code == code_pedestal) begin
            fixed_pedestal[gc] <= bus_in[9:0];
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      suppression_offset_threshold <= cfg_reset;
      baseline_window_thresholds <= cfg_reset;
      acquisition_window_config <= cfg_reset;
      datapath_config <= cfg_reset;
      buffers_pretrigger_config <= 7'h00;
      pedestal_memory_word <= 10'h000;
      pedestal_memory_pointer <= 10'h000;
    end else if (reg_wr) begin
      unique case (code)
        code_zs_thr: suppression_offset_threshold <= bus_in[19:0];
        code_bc_thr: baseline_window_thresholds <= bus_in[19:0];
        code_acq_cfg: acquisition_window_config <= bus_in[19:0];
        code_dp_cfg: datapath_config <= bus_in[19:0];
        code_buf_cfg: buffers_pretrigger_config <= bus_in[6:0];
        code_ped_word: pedestal_memory_word <= bus_in[9:0];
        code_ped_ptr: pedestal_memory_pointer <= bus_in[9:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pretrigger_samples <= 4'h0;
      power_save <= 1'b0;
      filter_force <= 1'b0;
      eight_buffers <= 1'b0;
    end else begin
      // code 15 clamps to the 14 samples held in the pipeline
      pretrigger_samples <= (buffers_pretrigger_config[3:0] == pretrig_code_top)
        ? pretrig_max : buffers_pretrigger_config[3:0];
      power_save <= buffers_pretrigger_config[6];
      filter_force <= buffers_pretrigger_config[5];
      eight_buffers <= buffers_pretrigger_config[buf_count_bit];
    end
  end

  // error events at their status positions; parity is never checked
  always_comb begin
    err_set = 8'h00;
    err_set[err_readout - err_parity] = dump_empty;
    err_set[err_overlap - err_parity] = trig_any && acquisition_busy;
    err_set[err_instr - err_parity] = take && (!valid_code || bad_mode);
  end

  // sticky errors: a new error in the clear cycle survives
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      errors <= 8'h00;
    end else if (clr_err) begin
      errors <= err_set;
    end else begin
      errors <= errors | err_set;
    end
  end

  always_comb begin
    next_read_value = 20'h0_0000;
    unique case (code)
      code_pole_1,
      code_pole_2,
      code_pole_3,
      code_zero_1,
      code_zero_2,
      code_zero_3: next_read_value = {4'h0, coeff[chan][code[2:0]]};
      code_pedestal: next_read_value = {pedestal_variable, fixed_pedestal[chan]};
      code_ped_word: next_read_value = {10'h000, pedestal_memory_word};
      code_zs_thr: next_read_value = suppression_offset_threshold;
      code_bc_thr: next_read_value = baseline_window_thresholds;
      code_acq_cfg: next_read_value = acquisition_window_config;
      code_dp_cfg: next_read_value = datapath_config;
      code_buf_cfg: next_read_value = {13'h0000, buffers_pretrigger_config};
      code_ped_ptr: next_read_value = {10'h000, pedestal_memory_pointer};
      code_status: next_read_value = {errors, empty, full, remaining, write_pointer,
        read_pointer};
      code_id_len: next_read_value = {4'h0, hardwired_chip_id, event_length};
      code_trig_cnt: next_read_value = {4'h0, level_one_trigger_count};
      default: next_read_value = 20'h0_0000;
    endcase
  end

  // instruction handshake and dump sequencer
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state <= st_idle;
      ack_n <= 1'b1;
      dump_go <= 1'b0;
      dump_count <= 8'h00;
      gap_count <= 2'h0;
      transfer_active <= 1'b0;
      data_strobe_n <= 1'b1;
      bus_oe <= 40'h00_0000_0000;
      bus_out <= 40'h00_0000_0000;
    end else begin
      unique case (state)
        st_idle: begin
          if (take) begin
            ack_n <= 1'b0;
            dump_go <= dump_req && !empty;
            state <= st_ack;
            // refused reads answer zeros so the low half never floats
            if (is_read) begin
              bus_oe <= {20'h0_0000, 20'hF_FFFF};
              bus_out <= {20'h0_0000, (valid_code && !bad_mode) ? next_read_value : 20'h0_0000};
            end
          end
        end
        st_ack: begin
          if (instr_strobe_n) begin
            ack_n <= 1'b1;
            bus_oe <= 40'h00_0000_0000;
            gap_count <= dump_gap;
            // a valid dump with data waiting takes the bus
            state <= dump_go ? st_gap : st_idle;
          end
        end
        st_gap: begin
          gap_count <= gap_count - 2'h1;
          if (gap_count == 2'h1) begin
            bus_oe <= 40'hFF_FFFF_FFFF;
            dump_count <= event_length == 8'h00 ? dump_words_default : event_length;
            state <= st_drive;
          end
        end
        st_drive: begin
          transfer_active <= 1'b1;
          state <= st_xfer;
        end
        st_xfer: begin
          if (!data_strobe_n) begin
            // a word counts at its falling strobe, so a pause never repeats it
            data_strobe_n <= 1'b1;
            if (dump_count == 8'h00) begin
              transfer_active <= 1'b0;
              state <= st_release;
            end
          end else if (!acquisition_busy) begin
            // a new trigger holds the strobe high until acquisition ends
            data_strobe_n <= 1'b0;
            bus_out <= dump_data;
            dump_count <= dump_count - 8'h01;
          end
        end
        st_release: begin
          data_strobe_n <= 1'b1;
          bus_oe <= 40'h00_0000_0000;
          state <= st_idle;
        end
        default: state <= st_idle;
      endcase
    end
  end
endmodule : event_buffer_command_control

// ---- inc/evbuf_pkg.sv ----
// Purpose: constants for the event buffer command and register control
// Assumes: one clock domain, 40-bit instruction word split into fields
// Notes: register codes are instruction codes on bits 24:20
package evbuf_pkg;
  localparam int num_channels = 16;
  localparam logic [4:0] code_pole_1 = 5'h00;
  localparam logic [4:0] code_pole_2 = 5'h01;
  localparam logic [4:0] code_pole_3 = 5'h02;
  localparam logic [4:0] code_zero_1 = 5'h03;
  localparam logic [4:0] code_zero_2 = 5'h04;
  localparam logic [4:0] code_zero_3 = 5'h05;
  localparam logic [4:0] code_pedestal = 5'h06;
  localparam logic [4:0] code_ped_word = 5'h07;
  localparam logic [4:0] code_zs_thr = 5'h08;
  localparam logic [4:0] code_bc_thr = 5'h09;
  localparam logic [4:0] code_acq_cfg = 5'h0A;
  localparam logic [4:0] code_dp_cfg = 5'h0B;
  localparam logic [4:0] code_buf_cfg = 5'h0C;
  localparam logic [4:0] code_ped_ptr = 5'h0D;
  localparam logic [4:0] code_status = 5'h10;
  localparam logic [4:0] code_id_len = 5'h11;
  localparam logic [4:0] code_trig_cnt = 5'h12;
  localparam logic [4:0] code_wp_adv = 5'h18;
  localparam logic [4:0] code_rp_adv = 5'h19;
  localparam logic [4:0] code_dump = 5'h1A;
  localparam logic [4:0] code_soft_trig = 5'h1B;
  localparam logic [4:0] code_clr_trig = 5'h1C;
  localparam logic [4:0] code_clr_err = 5'h1D;
  // error bit positions within the upper byte of the status word
  localparam int err_parity = 12;
  localparam int err_instr = 13;
  localparam int err_overlap = 14;
  localparam int err_readout = 19;
  // field positions
  localparam int broadcast_flag_bit = 38;
  localparam int buf_count_bit = 4;
  localparam int zs_enable_bit = 19;
  localparam int ma_enable_bit = 11;
  localparam int polarity_bit = 4;
  localparam logic [3:0] pretrig_max = 4'hE;
  localparam logic [3:0] pretrig_code_top = 4'hF;
  localparam logic [15:0] trig_count_reset = 16'h0000;
  localparam logic [19:0] cfg_reset = 20'h0_0000;
  localparam logic [7:0] dump_words_default = 8'h04;
  localparam logic [1:0] dump_gap = 2'h3;
  typedef enum logic [2:0] {
    st_idle = 3'b000,
    st_ack = 3'b001,
    st_gap = 3'b011,
    st_drive = 3'b010,
    st_xfer = 3'b110,
    st_release = 3'b111
  } bus_state_t;
endpackage : evbuf_pkg

// ---- bench/evbuf_checker.sv ----
// Purpose: port-level checks of bus ownership, pointer steps and answers
// Assumes: single ref_clk domain, reset synchronous and active high
// Notes: dump_data is held still by the bench while a dump runs
`timescale 1ns/1ns
module evbuf_checker (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [39:0] bus_out,
  input wire logic [39:0] bus_oe,
  input wire logic write_n,
  input wire logic ack_n,
  input wire logic transfer_active,
  input wire logic data_strobe_n,
  input wire logic [39:0] dump_data,
  input wire logic trigger_pulse,
  input wire logic [2:0] write_pointer,
  input wire logic [2:0] read_pointer,
  input wire logic [3:0] pretrigger_samples,
  input wire logic eight_buffers
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  a_dump_owns_bus: assert property (transfer_active |-> &bus_oe)
    else $error("bus not driven during transfer");
  a_dump_prelude: assert property (
    $rose(transfer_active) |-> $past(bus_oe) == 40'hFF_FFFF_FFFF)
    else $error("transfer began before bus was taken");
  a_bus_release: assert property ($fell(transfer_active) |=> !(|bus_oe))
    else $error("bus kept after transfer");
  a_word_valid: assert property (
    !data_strobe_n |-> transfer_active && bus_out == $past(dump_data))
    else $error("word strobe without transfer data");
  a_ack_answer: assert property (!ack_n |-> bus_oe == {20'h0_0000, {20{write_n}}})
    else $error("answer drive wrong while acknowledging");
  a_wp_step: assert property (write_pointer != $past(write_pointer) |->
    write_pointer == 3'($past(write_pointer) + ($past(eight_buffers) ? 1 : 2)))
    else $error("write pointer stepped wrongly");
  a_rp_step: assert property (read_pointer != $past(read_pointer) |->
    read_pointer == 3'($past(read_pointer) + ($past(eight_buffers) ? 1 : 2)))
    else $error("read pointer stepped wrongly");
  a_even_pointers: assert property (
    !eight_buffers |-> !write_pointer[0] && !read_pointer[0])
    else $error("odd pointer in four-buffer mode");
  a_pretrig_clamp: assert property (pretrigger_samples != 4'hF)
    else $error("pretrigger count above fourteen");
  a_trig_one_cycle: assert property (trigger_pulse |=> !trigger_pulse)
    else $error("trigger pulse longer than one cycle");
  cover property ($rose(transfer_active));
  cover property (trigger_pulse);
  cover property (eight_buffers && write_pointer[0]);
endmodule : evbuf_checker

bind event_buffer_command_control evbuf_checker chk_u (
  .ref_clk(ref_clk), .reset(reset), .bus_out(bus_out), .bus_oe(bus_oe), .write_n(write_n),
  .ack_n(ack_n), .transfer_active(transfer_active), .data_strobe_n(data_strobe_n),
  .dump_data(dump_data), .trigger_pulse(trigger_pulse), .write_pointer(write_pointer),
  .read_pointer(read_pointer), .pretrigger_samples(pretrigger_samples),
  .eight_buffers(eight_buffers)
);

// ---- bench/readout_controller_model.sv ----
// Purpose: readout controller on the far side of the instruction bus
// Assumes: the device drives bus_out wherever bus_oe is high
// Notes: undriven lines flip every cycle so stale values never pass
`timescale 1ns/1ns
module readout_controller_model (
  input wire logic ref_clk,
  input wire logic [39:0] bus_out,
  input wire logic [39:0] bus_oe,
  input wire logic ack_n,
  output logic [39:0] bus_in,
  output logic instr_strobe_n,
  output logic write_n
);
  logic [39:0] drv = 40'h00_0000_0000;
  logic [39:0] drv_en = 40'h00_0000_0000;
  logic [39:0] filler = 40'hA5_5A5A_A55A;
  initial begin
    instr_strobe_n = 1'b1;
    write_n = 1'b1;
  end
  always @(posedge ref_clk) filler <= ~filler;
  assign bus_in = (bus_oe & bus_out) | (~bus_oe & drv_en & drv) | (~bus_oe & ~drv_en & filler);
  task automatic issue(input logic wn, input logic [19:0] hi, input logic [19:0] arg,
      output logic [19:0] rd, output logic ok);
    int i;
    repeat ($urandom_range(1, 3)) @(posedge ref_clk);
    #1 drv = {hi, arg};
    drv_en = {20'hF_FFFF, (!wn && hi[4:0] < 5'h18) ? 20'hF_FFFF : 20'h0_0000};
    write_n = wn;
    instr_strobe_n = 1'b0;
    for (i = 0; i < 40 && ack_n !== 1'b0; i++) begin
      @(posedge ref_clk);
      #1;
    end
    rd = bus_in[19:0];
    ok = ack_n === 1'b0;
    instr_strobe_n = 1'b1;
    for (i = 0; i < 40 && ack_n !== 1'b1; i++) begin
      @(posedge ref_clk);
      #1;
    end
    ok = ok && ack_n === 1'b1;
    drv_en = 40'h00_0000_0000;
  endtask : issue
endmodule : readout_controller_model

// ---- bench/tb_top.sv ----
// Purpose: self-checking bench for the event buffer command control
// Assumes: controller model drives the bus; pointers predicted here
// Notes: dump data held still, so its capture latency does not matter
`timescale 1ns/1ns
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module tb_top
  import evbuf_pkg::*;
;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic level_one_trigger = 1'b0;
  logic acquisition_busy = 1'b0;
  logic [7:0] hardwired_chip_id, event_length;
  logic [9:0] pedestal_variable;
  logic [39:0] dump_data, bus_in, bus_out, bus_oe;
  logic instr_strobe_n, write_n, ack_n, transfer_active, data_strobe_n, trigger_pulse;
  logic [2:0] write_pointer, read_pointer;
  logic [19:0] zs_thr, bc_thr, acq_cfg, dp_cfg, v, r;
  logic [3:0] pretrigger_samples;
  logic power_save, filter_force, eight_buffers;
  logic [7:0] err = 8'h00;
  logic [19:0] regv [12];
  int wp = 0, rp = 0, cnt = 0, nbuf = 4, trigs = 0, i;
  int n_mismatch = 0, n_compared = 0;
  event_buffer_command_control dut_u (
    .ref_clk(ref_clk), .reset(reset), .bus_in(bus_in), .bus_out(bus_out), .bus_oe(bus_oe),
    .instr_strobe_n(instr_strobe_n), .write_n(write_n), .ack_n(ack_n),
    .transfer_active(transfer_active), .data_strobe_n(data_strobe_n),
    .level_one_trigger(level_one_trigger), .acquisition_busy(acquisition_busy),
    .hardwired_chip_id(hardwired_chip_id), .pedestal_variable(pedestal_variable),
    .event_length(event_length), .dump_data(dump_data), .trigger_pulse(trigger_pulse),
    .write_pointer(write_pointer), .read_pointer(read_pointer),
    .suppression_offset_threshold(zs_thr), .baseline_window_thresholds(bc_thr),
    .acquisition_window_config(acq_cfg), .datapath_config(dp_cfg),
    .pretrigger_samples(pretrigger_samples), .power_save(power_save),
    .filter_force(filter_force), .eight_buffers(eight_buffers)
  );
  readout_controller_model ctl_u (
    .ref_clk(ref_clk), .bus_out(bus_out), .bus_oe(bus_oe), .ack_n(ack_n), .bus_in(bus_in),
    .instr_strobe_n(instr_strobe_n), .write_n(write_n)
  );
  initial forever #5 ref_clk = ~ref_clk;
  function automatic logic [19:0] st();
    return {err, cnt == 0, cnt == nbuf, 4'(nbuf - cnt), 3'(wp), 3'(rp)};
  endfunction : st
  task automatic summarize();
    $display("compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : summarize
  task automatic op(input logic wn, input logic [4:0] code, input logic [4:0] ch,
      input logic [19:0] arg, output logic [19:0] rd);
    logic ok;
    ctl_u.issue(wn, {1'b0, ch[4], 1'b0, hardwired_chip_id, ch[3:0], code}, arg, rd, ok);
    if (!ok) begin
      n_mismatch++;
      summarize();
    end
  endtask : op
  task automatic wr(input logic [4:0] code, input logic [4:0] ch, input logic [19:0] arg);
    op(1'b0, code, ch, arg, r);
  endtask : wr
  task automatic rd(input logic [4:0] code, input logic [4:0] ch, input logic [19:0] e);
    logic [19:0] g;
    op(1'b1, code, ch, 20'h0_0000, g);
    `CHK(g, e)
  endtask : rd
  task automatic advance(input logic [4:0] code);
    wr(code, 5'h00, 20'h0_0000);
    if (code == code_wp_adv && cnt < nbuf) begin
      wp = (wp + 8 / nbuf) % 8;
      cnt++;
    end
    if (code == code_rp_adv && cnt > 0) begin
      rp = (rp + 8 / nbuf) % 8;
      cnt--;
    end
    rd(code_status, 5'h00, st());
  endtask : advance
  task automatic trig();
    @(posedge ref_clk);
    #1 level_one_trigger = 1'b1;
    @(posedge ref_clk);
    #1 level_one_trigger = 1'b0;
    acquisition_busy = 1'b1;
    `CHK(trigger_pulse, 1'(cnt != nbuf))
    trigs++;
    repeat (3) @(posedge ref_clk);
    // pointer advance only once acquisition has ended
    #1 acquisition_busy = 1'b0;
  endtask : trig
  task automatic dump(input int words);
    int n, j;
    logic prev;
    n = 0;
    prev = 1'b1;
    wr(code_dump, 5'h05, 20'h0_0000);
    // no instruction while the device owns the bus
    for (j = 0; j < 60; j++) begin
      @(posedge ref_clk);
      #1 acquisition_busy = (j >= 4 && j < 9);
      level_one_trigger = (j == 5);
      if (prev && data_strobe_n === 1'b0) begin
        n++;
        `CHK(bus_out, dump_data)
      end
      prev = data_strobe_n;
    end
    trigs++;
    err[2] = 1'b1;
    `CHK(n, words)
  endtask : dump
  initial begin
    v = $urandom(32'hd906c87c);
    hardwired_chip_id = 8'($urandom);
    pedestal_variable = 10'($urandom);
    event_length = 8'h00;
    dump_data = {8'($urandom), $urandom};
    repeat (8) @(posedge ref_clk);
    #1 reset = 1'b0;
    rd(code_status, 5'h00, st());
    rd(code_trig_cnt, 5'h00, 20'h0_0000);
    for (i = 0; i < 12; i++) begin
      if (i == 6 || i == 7) continue;
      rd(5'(i), 5'(i), 20'h0_0000);
      v = 20'($urandom);
      if (i < 6) v[19:16] = 4'h0;
      if (i == 10) v[9:0] = 10'($urandom_range(0, 1000));
      wr(5'(i), 5'(i), v);
      rd(5'(i), 5'(i), v);
      regv[i] = v;
    end
    `CHK(zs_thr, regv[8])
    `CHK(bc_thr, regv[9])
    `CHK(acq_cfg, regv[10])
    `CHK(dp_cfg, regv[11])
    v = 20'($urandom);
    wr(code_pedestal, 5'h02, v);
    rd(code_pedestal, 5'h02, {pedestal_variable, v[9:0]});
    v = 20'($urandom_range(0, 65535));
    wr(code_pole_2, 5'h10, v);
    for (i = 0; i < 16; i += 5) rd(code_pole_2, 5'(i), v);
    wr(code_buf_cfg, 5'h00, 20'h0_004F);
    `CHK({power_save, filter_force, eight_buffers, pretrigger_samples}, 7'h4E)
    event_length = 8'($urandom);
    rd(code_id_len, 5'h03, {4'h0, hardwired_chip_id, event_length});
    wr(code_status, 5'h00, 20'h0_0000);
    op(1'b1, 5'h0E, 5'h00, 20'h0_0000, r);
    err[1] = 1'b1;
    rd(code_status, 5'h00, st());
    for (i = 0; i < 5; i++) begin
      trig();
      advance(code_wp_adv);
    end
    rd(code_trig_cnt, 5'h00, 20'(trigs));
    advance(code_rp_adv);
    for (i = 0; i < 2; i++) begin
      event_length = 8'(i * $urandom_range(1, 12));
      dump(i ? int'(event_length) : 4);
    end
    rd(code_status, 5'h00, st());
    wr(code_clr_err, 5'h00, 20'h0_0000);
    err = 8'h00;
    rd(code_status, 5'h00, st());
    for (i = 0; i < 4; i++) advance(code_rp_adv);
    err[7] = 1'b1;
    dump(0);
    wr(code_soft_trig, 5'h00, 20'h0_0000);
    trigs++;
    rd(code_trig_cnt, 5'h00, 20'(trigs));
    wr(code_clr_trig, 5'h00, 20'h0_0000);
    trigs = 0;
    rd(code_trig_cnt, 5'h00, 20'h0_0000);
    wr(code_buf_cfg, 5'h00, 20'h0_0010);
    nbuf = 8;
    for (i = 0; i < 9; i++) begin
      trig();
      advance(code_wp_adv);
    end
    for (i = 0; i < 3; i++) advance(code_rp_adv);
    @(posedge ref_clk);
    #1 reset = 1'b1;
    repeat (3) @(posedge ref_clk);
    #1 reset = 1'b0;
    {wp, rp, cnt, trigs, nbuf, err} = {32'd0, 32'd0, 32'd0, 32'd0, 32'd4, 8'h00};
    rd(code_status, 5'h00, st());
    rd(code_acq_cfg, 5'h00, 20'h0_0000);
    summarize();
  end
endmodule : tb_top
